// [sss_scan_driver.sv]
// Purpose: scan a 4 or 8 digit BCD value onto a multiplexed display
// Assumes: scan_tick marks one controller scan cycle, same clock
// Notes:   bits the scan does not own follow gpo_word
//
// What this block does
// - execution condition low: no scan activity, lines left alone
// - execution condition high: read digits, drive display data
// - codes 0-3 use first word only, 4-7 use two words
// - low two bits invert latch lines, data lines, or both
// - 8-digit: upper four digits from second word
// - one round takes twelve scan cycles then restarts
// - scanning starts on the first scan after program start
// - scan owns 9 output bits for 4 digits, 13 for 8
// - 4-digit: data on bits 0-3, latches on bits 4-7
// - round complete bit at 8 or 12 after a full round
// - unused output bits stay general purpose outputs
// - 8-digit: data bits 0-3 and 4-7, latches bits 8-11
// - error on split memory areas in 8-digit mode or bad operand settings
// - executing flag high while the block is active

`timescale 1ns/1ps

module sss_scan_driver
  import sss_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              scan_tick,
  input  wire logic              prog_start,
  input  wire logic              exec_cond,
  input  wire logic [SV_W-1:0]   setting_value,
  input  wire logic              same_area,
  input  wire logic [WORD_W-1:0] src_word_lo,
  input  wire logic [WORD_W-1:0] src_word_hi,
  input  wire logic [OUT_W-1:0]  gpo_word,
  output logic [OUT_W-1:0]       segment_scan_output,
  output logic                   executing_flag,
  output logic                   error_flag
);

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  logic              mode_8dig;
  logic              latch_inv;
  logic              data_inv;
  logic              cfg_err;
  logic              advance;

  assign mode_8dig = setting_value[SV_8DIG_B];
  assign latch_inv = setting_value[SV_LATCH_INV_B];
  assign data_inv  = setting_value[SV_DATA_INV_B];
  assign cfg_err   = (setting_value > SV_MAX)
                   || (mode_8dig && !same_area);
  assign advance   = scan_tick && exec_cond && !cfg_err;

  // ---------------------------------------------------------------
  // step counter and digit selection
  // ---------------------------------------------------------------
  logic [STEP_W-1:0] step_cur;
  logic              wrap;
  logic [DIG_W-1:0]  digit_sel;
  logic              latching;
  logic [NIB_W-1:0]  nib_lo;
  logic [NIB_W-1:0]  nib_hi;

  sss_step_counter u_step (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .restart  (prog_start),
    .advance  (advance),
    .step_cur (step_cur),
    .wrap     (wrap)
  );

  assign digit_sel = step_digit(step_cur);
  assign latching  = step_latching(step_cur);

  sss_digit_pick u_pick_lo (
    .word   (src_word_lo),
    .digit  (digit_sel),
    .nibble (nib_lo)
  );

  sss_digit_pick u_pick_hi (
    .word   (src_word_hi),
    .digit  (digit_sel),
    .nibble (nib_hi)
  );

  // ---------------------------------------------------------------
  // round complete flag
  // ---------------------------------------------------------------
  logic round_reg;
  logic round_next;

  // set on wrap wins over the restart clear
  assign round_next = wrap || (round_reg && !prog_start);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      round_reg <= 1'b0;
    end else if (advance || prog_start) begin
      round_reg <= round_next;
    end
  end

  // ---------------------------------------------------------------
  // scan field build
  // ---------------------------------------------------------------
  logic [NIB_W-1:0]  latch_native;
  logic [NIB_W-1:0]  latch_drv;
  logic [NIB_W-1:0]  data_lo_drv;
  logic [NIB_W-1:0]  data_hi_drv;
  logic [FLD_W-1:0]  field_next;
  logic [FLD_W-1:0]  scan_field_reg;
  logic [OUT_W-1:0]  mask_next;
  logic [OUT_W-1:0]  mask_reg;

  always_comb begin
    latch_native = '0;
    if (latching) begin
      latch_native[digit_sel] = 1'b1;
    end
  end

  assign latch_drv   = latch_native ^ {NIB_W{latch_inv}};
  assign data_lo_drv = nib_lo ^ {NIB_W{data_inv}};
  assign data_hi_drv = nib_hi ^ {NIB_W{data_inv}};

  always_comb begin
    field_next = FLD_RST;
    if (mode_8dig) begin
      field_next[DATA_LO_POS +: NIB_W] = data_lo_drv;
      field_next[DATA_HI_POS +: NIB_W] = data_hi_drv;
      field_next[LATCH8_POS +: NIB_W]  = latch_drv;
      field_next[ROUND8_POS]           = round_next;
    end else begin
      field_next[DATA_LO_POS +: NIB_W] = data_lo_drv;
      field_next[LATCH4_POS +: NIB_W]  = latch_drv;
      field_next[ROUND4_POS]           = round_next;
    end
  end

  assign mask_next = advance ? (mode_8dig ? MASK8 : MASK4)
                             : mask_reg;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scan_field_reg <= FLD_RST;
    end else if (advance) begin
      scan_field_reg <= field_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= MASK_NONE;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ---------------------------------------------------------------
  // output word merge
  // ---------------------------------------------------------------
  logic [OUT_W-1:0] field_ext;

  assign field_ext = {{(OUT_W-FLD_W){1'b0}},
                      (advance ? field_next : scan_field_reg)};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      segment_scan_output <= '0;
    end else begin
      segment_scan_output <= (field_ext & mask_next)
                           | (gpo_word & ~mask_next);
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      executing_flag <= 1'b0;
    end else begin
      executing_flag <= exec_cond && !cfg_err;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      error_flag <= 1'b0;
    end else begin
      error_flag <= exec_cond && cfg_err;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  AST_IDLE_HOLDS: assert property (
    !exec_cond |=> $stable(scan_field_reg) && $stable(mask_reg))
    else $error("scan moved while execution condition low");

  AST_STEP_WRAPS: assert property (
    advance && step_cur == STEP_LAST && !prog_start
      |=> !prog_start |-> step_cur == STEP_FIRST)
    else $error("round did not restart after twelve steps");

  AST_STEP_ADVANCES: assert property (
    advance && step_cur != STEP_LAST ##1 !prog_start
      |-> step_cur == $past(step_cur) + STEP_ONE)
    else $error("step did not advance on scan");

  AST_ROUND_SET: assert property (
    wrap |=> round_reg)
    else $error("round flag not set after full round");

  AST_RESTART_ZERO: assert property (
    prog_start && !advance |=> !prog_start |-> step_cur == STEP_FIRST)
    else $error("scan did not start from first step");

  AST_GPO_PASS: assert property (
    1'b1 |=> ((segment_scan_output & ~$past(mask_next))
              == ($past(gpo_word) & ~$past(mask_next))))
    else $error("unused output bit altered by scan");

  AST_MASK4: assert property (
    advance && !mode_8dig |=> mask_reg == MASK4)
    else $error("4-digit mode owns wrong bits");

  AST_DATA4: assert property (
    advance && !mode_8dig |=> segment_scan_output[NIB_W-1:0]
      == ($past(nib_lo) ^ {NIB_W{$past(data_inv)}}))
    else $error("4-digit data nibble wrong");

  AST_HI8: assert property (
    advance && mode_8dig |=> segment_scan_output[DATA_HI_POS +: NIB_W]
      == ($past(nib_hi) ^ {NIB_W{$past(data_inv)}}))
    else $error("upper digits not from second word");

  AST_LATCH8: assert property (
    advance && mode_8dig |=> $onehot0(
      segment_scan_output[LATCH8_POS +: NIB_W]
      ^ {NIB_W{$past(latch_inv)}}))
    else $error("more than one latch strobe active");

  AST_ERR_FLAG: assert property (
    exec_cond && setting_value > SV_MAX |=> error_flag && !executing_flag)
    else $error("bad setting value not flagged");

  AST_EXEC_FLAG: assert property (
    exec_cond && !cfg_err |=> executing_flag)
    else $error("executing flag missing while active");

  AST_MASK8: assert property (
    advance && mode_8dig |=> mask_reg == MASK8)
    else $error("8-digit mode owns wrong bits");

  AST_LATCH4: assert property (
    advance && !mode_8dig |=> $onehot0(
      segment_scan_output[LATCH4_POS +: NIB_W]
      ^ {NIB_W{$past(latch_inv)}}))
    else $error("more than one 4-digit latch strobe active");

  AST_LO8: assert property (
    advance && mode_8dig |=> segment_scan_output[DATA_LO_POS +: NIB_W]
      == ($past(nib_lo) ^ {NIB_W{$past(data_inv)}}))
    else $error("lower digits not from first word");

  AST_ROUND_BIT4: assert property (
    advance && !mode_8dig |=> segment_scan_output[ROUND4_POS]
      == $past(round_next))
    else $error("4-digit round bit wrong");

  AST_ROUND_BIT8: assert property (
    advance && mode_8dig |=> segment_scan_output[ROUND8_POS]
      == $past(round_next))
    else $error("8-digit round bit wrong");

  AST_ROUND_HOLD: assert property (
    !wrap && !prog_start |=> $stable(round_reg))
    else $error("round flag changed without wrap or restart");

  AST_SPLIT_ERR: assert property (
    exec_cond && mode_8dig && !same_area |=> error_flag && !executing_flag)
    else $error("split source areas not flagged");

  AST_IDLE_FLAGS: assert property (
    !exec_cond |=> !executing_flag && !error_flag)
    else $error("status flags set while execution condition low");

  AST_FLAGS_EXCL: assert property (
    error_flag |-> !executing_flag)
    else $error("error and executing flags both set");

  AST_STEP_RANGE: assert property (
    step_cur <= STEP_LAST)
    else $error("step counter left the round");

  COV_ROUND4: cover property (wrap && !mode_8dig);
  COV_ROUND8: cover property (wrap && mode_8dig);
  COV_INV_BOTH: cover property (advance && latch_inv && data_inv);
  COV_SPLIT_AREA: cover property (exec_cond && mode_8dig && !same_area);
  COV_RESTART_DONE: cover property (prog_start && round_reg);

endmodule

// [sss_pkg.sv]
// Purpose: shared constants for the seven segment scan driver
// Assumes: one clock, scan cycles arrive as a one-cycle enable
// Notes:   all positions and counts of the output word live here

package sss_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned OUT_W  = 16;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned NIB_W  = 4;
  localparam int unsigned STEP_W = 4;
  localparam int unsigned DIG_W  = 2;
  localparam int unsigned SV_W   = 4;
  localparam int unsigned FLD_W  = 13;

  // ---------------------------------------------------------------
  // round timing
  // ---------------------------------------------------------------
  localparam logic [STEP_W-1:0] STEP_FIRST   = 4'h0;
  localparam logic [STEP_W-1:0] STEP_LAST    = 4'hb;
  localparam logic [STEP_W-1:0] STEP_ONE     = 4'h1;
  localparam logic [STEP_W-1:0] STEPS_PER_DG = 4'h3;
  localparam logic [STEP_W-1:0] LATCH_PHASE  = 4'h1;

  // ---------------------------------------------------------------
  // setting value decode
  // ---------------------------------------------------------------
  localparam logic [SV_W-1:0] SV_MAX         = 4'h7;
  localparam int unsigned     SV_LATCH_INV_B = 0;
  localparam int unsigned     SV_DATA_INV_B  = 1;
  localparam int unsigned     SV_8DIG_B      = 2;

  // ---------------------------------------------------------------
  // output word layout
  // ---------------------------------------------------------------
  localparam int unsigned DATA_LO_POS  = 0;
  localparam int unsigned DATA_HI_POS  = 4;
  localparam int unsigned LATCH4_POS   = 4;
  localparam int unsigned LATCH8_POS   = 8;
  localparam int unsigned ROUND4_POS   = 8;
  localparam int unsigned ROUND8_POS   = 12;
  localparam logic [OUT_W-1:0] MASK4   = 16'h01ff;
  localparam logic [OUT_W-1:0] MASK8   = 16'h1fff;
  localparam logic [OUT_W-1:0] MASK_NONE = 16'h0000;
  localparam logic [FLD_W-1:0] FLD_RST = 13'h0000;

  // ---------------------------------------------------------------
  // step decode helpers
  // ---------------------------------------------------------------
  function automatic logic [DIG_W-1:0] step_digit(
    input logic [STEP_W-1:0] step
  );
    logic [STEP_W-1:0] q;
    q = step / STEPS_PER_DG;
    return q[DIG_W-1:0];
  endfunction

  function automatic logic step_latching(input logic [STEP_W-1:0] step);
    return (step % STEPS_PER_DG) == LATCH_PHASE;
  endfunction

endpackage

// [sss_step_counter.sv]
// Purpose: modulo twelve step counter for one display round
// Assumes: advance is a one-cycle enable, restart a one-cycle pulse
// Notes:   restart forces step zero and may coincide with advance

`timescale 1ns/1ps

module sss_step_counter
  import sss_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              restart,
  input  wire logic              advance,
  output logic [STEP_W-1:0]      step_cur,
  output logic                   wrap
);

  logic [STEP_W-1:0] step_reg;

  // ---------------------------------------------------------------
  // current step and wrap
  // ---------------------------------------------------------------
  assign step_cur = restart ? STEP_FIRST : step_reg;
  assign wrap     = advance && (step_cur == STEP_LAST);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      step_reg <= STEP_FIRST;
    end else if (advance) begin
      step_reg <= wrap ? STEP_FIRST : step_cur + STEP_ONE;
    end else begin
      step_reg <= step_cur;
    end
  end

endmodule

// [sss_digit_pick.sv]
// Purpose: pick one BCD digit out of a source word
// Assumes: digit 0 is the least significant nibble
// Notes:   purely combinational

`timescale 1ns/1ps

module sss_digit_pick
  import sss_pkg::*;
(
  input  wire logic [WORD_W-1:0] word,
  input  wire logic [DIG_W-1:0]  digit,
  output logic [NIB_W-1:0]       nibble
);

  // ---------------------------------------------------------------
  // nibble select
  // ---------------------------------------------------------------
  always_comb begin
    nibble = word[NIB_W*digit +: NIB_W];
  end

endmodule

// [sss_display_model.sv]
// Purpose: behavioural multiplexed seven segment display with digit latches
// Assumes: latch lines are level sensitive, sampled on core_clk
// Notes:   shows the last latched digit of each position

`timescale 1ns/1ps

module sss_display_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] seg_in,
  input  wire logic        eight_dig,
  input  wire logic        data_inv,
  input  wire logic        latch_inv,
  output logic      [15:0] shown_lo,
  output logic      [15:0] shown_hi
);
  // ---------------------------------------------------------------
  // four data lines per word, one latch line per digit position
  // ---------------------------------------------------------------
  logic [3:0] strobe;
  logic [3:0] dlo;
  logic [3:0] dhi;

  assign strobe = (eight_dig ? seg_in[11:8] : seg_in[7:4]) ^ {4{latch_inv}};
  assign dlo    = seg_in[3:0] ^ {4{data_inv}};
  assign dhi    = seg_in[7:4] ^ {4{data_inv}};

  initial begin
    shown_lo = 16'h0000;
    shown_hi = 16'h0000;
  end

  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (strobe[i]) begin
        shown_lo[4*i+:4] <= dlo;
        if (eight_dig) begin
          shown_hi[4*i+:4] <= dhi;
        end
      end
    end
  end
endmodule

// [sss_tb.sv]
// Purpose: self-checking bench for the seven segment scan driver
// Assumes: inputs change on the falling edge, model runs on rising edge
// Notes:   random soak against a cycle model, then one round per code

`timescale 1ns/1ps

module tb
  import sss_pkg::*;
;
  logic              core_clk;
  logic              rst_b;
  logic              scan_tick;
  logic              prog_start;
  logic              exec_cond;
  logic [SV_W-1:0]   setting_value;
  logic              same_area;
  logic [WORD_W-1:0] src_word_lo;
  logic [WORD_W-1:0] src_word_hi;
  logic [OUT_W-1:0]  gpo_word;
  logic [OUT_W-1:0]  segment_scan_output;
  logic              executing_flag;
  logic              error_flag;
  logic [15:0]       shown_lo;
  logic [15:0]       shown_hi;
  int                err_total;
  int                num_checks;
  logic              live;
  logic [15:0]       e_out;
  logic              e_ex;
  logic              e_er;
  logic [3:0]        st;
  logic [3:0]        s;
  logic              rf;
  logic              bad;
  logic              adv;
  logic [15:0]       msk;
  logic [15:0]       fld;

  // ---------------------------------------------------------------
  // clock, design and display
  // ---------------------------------------------------------------
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  sss_scan_driver DUT (
    .core_clk(core_clk), .rst_b(rst_b), .scan_tick(scan_tick),
    .prog_start(prog_start), .exec_cond(exec_cond),
    .setting_value(setting_value), .same_area(same_area),
    .src_word_lo(src_word_lo), .src_word_hi(src_word_hi),
    .gpo_word(gpo_word), .segment_scan_output(segment_scan_output),
    .executing_flag(executing_flag), .error_flag(error_flag)
  );

  // single display on the single scanner
  sss_display_model disp (
    .core_clk(core_clk), .seg_in(segment_scan_output),
    .eight_dig(setting_value[2]), .data_inv(setting_value[1]),
    .latch_inv(setting_value[0]), .shown_lo(shown_lo),
    .shown_hi(shown_hi)
  );

  // ---------------------------------------------------------------
  // expected field of one step
  // ---------------------------------------------------------------
  function automatic logic [15:0] build(input logic [3:0] sp,
    input logic [3:0] sv, input logic [15:0] lo, input logic [15:0] hi,
    input logic r);
    logic [15:0] f;
    logic [3:0]  lat;
    logic [3:0]  dx;
    int          d;
    d   = int'(sp) / 3;
    lat = ((sp % 3) == 1) ? (4'h1 << d) : 4'h0;
    lat = lat ^ {4{sv[0]}};
    dx  = {4{sv[1]}};
    f   = 16'h0000;
    f[3:0] = lo[4*d+:4] ^ dx;
    if (sv[2]) begin
      f[7:4]  = hi[4*d+:4] ^ dx;
      f[11:8] = lat;
      f[12]   = r;
    end else begin
      f[7:4] = lat;
      f[8]   = r;
    end
    return f;
  endfunction

  // ---------------------------------------------------------------
  // cycle model
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      e_out <= 16'h0000;
      e_ex  <= 1'b0;
      e_er  <= 1'b0;
      st = 4'h0;
      rf = 1'b0;
      msk = 16'h0000;
      fld = 16'h0000;
    end else begin
      bad = (setting_value > 4'h7) || (setting_value[2] && !same_area);
      e_ex <= exec_cond && !bad;
      e_er <= exec_cond && bad;
      adv = scan_tick && exec_cond && !bad;
      s = prog_start ? 4'h0 : st;
      if (prog_start) rf = 1'b0;
      if (adv && s == 4'hb) rf = 1'b1;
      if (adv) begin
        fld = build(s, setting_value, src_word_lo, src_word_hi, rf);
        msk = setting_value[2] ? 16'h1fff : 16'h01ff;
        st = (s == 4'hb) ? 4'h0 : s + 4'h1;
      end else begin
        st = s;
      end
      e_out <= (fld & msk) | (gpo_word & ~msk);
    end
  end

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(negedge core_clk) begin
    if (live) begin
      chk("scan_out", segment_scan_output, e_out);
      chk("executing", {15'h0, executing_flag}, {15'h0, e_ex});
      chk("error", {15'h0, error_flag}, {15'h0, e_er});
    end
  end

  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial begin
    err_total = 0;
    num_checks = 0;
    live = 1'b0;
    rst_b = 1'b0;
    {scan_tick, prog_start, exec_cond, same_area} = 4'h0;
    setting_value = 4'h0;
    {src_word_lo, src_word_hi, gpo_word} = 48'h0;
    void'($urandom(32'h661ef044));
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    live = 1'b1;
    // random soak, illegal codes and split areas among it
    for (int n = 0; n < 4000; n++) begin
      @(negedge core_clk);
      scan_tick  = 1'($urandom % 2);
      exec_cond  = 1'(($urandom % 8) != 0);
      prog_start = 1'(($urandom % 64) == 0);
      same_area  = 1'(($urandom % 16) != 0);
      if (($urandom % 32) == 0) setting_value = 4'($urandom % 16);
      src_word_lo = 16'($urandom);
      src_word_hi = 16'($urandom);
      gpo_word    = 16'($urandom);
      if (n == 2000) rst_b = 1'b0;
      if (n == 2001) rst_b = 1'b1;
    end
    // one back-to-back round per legal code, read back from the display
    for (int c = 0; c < 8; c++) begin
      @(negedge core_clk);
      setting_value = 4'(c);
      same_area = 1'b1;
      exec_cond = 1'b1;
      src_word_lo = 16'($urandom);
      src_word_hi = 16'($urandom);
      prog_start = 1'b1;
      scan_tick = 1'b1;
      @(negedge core_clk);
      prog_start = 1'b0;
      repeat (11) @(negedge core_clk);
      scan_tick = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("shown_lo", shown_lo, src_word_lo);
      if (c > 3) chk("shown_hi", shown_hi, src_word_hi);
    end
    report_and_stop();
  end
endmodule
